// ===== pkg/ahbwc_pkg.sv
// Purpose: Shared constants and types for the host bus wait controller
// Assumes: 125 MHz core clock; host pins are asynchronous to it
// Notes:   Wait times are kept in ns and turned into clock counts here
package ahbwc_pkg;

    // Core clock
    localparam int CLK_PERIOD_NS = 8;

    // Pin and wait counter widths
    localparam int ADDR_W = 15;
    localparam int BE_W   = 4;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 4;

    // Typical host-ready low times, in ns, as printed
    localparam int READ_TURBO_WAIT_NS  = 40;
    localparam int READ_NORMAL_WAIT_NS = 80;
    localparam int WRITE_WAIT_NS       = 36;

    // Wait times as clock counts, rounded up to whole cycles
    localparam logic [CNT_W-1:0] READ_TURBO_CYCLES =
        CNT_W'((READ_TURBO_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] READ_NORMAL_CYCLES =
        CNT_W'((READ_NORMAL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WRITE_CYCLES =
        CNT_W'((WRITE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

    // Target decode on the word address
    localparam logic [ADDR_W-1:0] QUEUE_DATA_ADDR  = 15'h0008;
    localparam logic [ADDR_W-1:0] BANK_SELECT_ADDR = 15'h0007;

    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [BE_W-1:0]   BE_RST   = 4'hF;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

    // Synchroniser word layout, low bit first
    localparam int SYNC_ADS   = 0;
    localparam int SYNC_RD    = 1;
    localparam int SYNC_WR    = 2;
    localparam int SYNC_DCS   = 3;
    localparam int SYNC_AEN   = 4;
    localparam int SYNC_TURBO = 5;
    localparam int SYNC_LATCH = 6;
    localparam int SYNC_WIN   = 7;
    localparam int SYNC_BE    = 8;
    localparam int SYNC_ADDR  = SYNC_BE + BE_W;
    localparam int SYNC_DATA  = SYNC_ADDR + ADDR_W;
    localparam int SYNC_W     = SYNC_DATA + DATA_W;
    // Idle levels: strobes, select and byte enables high, rest low
    localparam logic [SYNC_W-1:0] SYNC_RST =
        {{DATA_W{1'b0}}, {ADDR_W{1'b0}}, {BE_W{1'b1}}, 4'h0, 4'hF};

    // Access sequencer states, one-hot
    typedef enum logic [3:0] {
        AHBWC_IDLE      = 4'b0001,
        AHBWC_READ_WAIT = 4'b0010,
        AHBWC_READ_HOLD = 4'b0100,
        AHBWC_WRITE_WAIT = 4'b1000
    } ahbwc_state_t;

    // Whole state of the controller
    typedef struct packed {
        ahbwc_state_t        state;
        logic [CNT_W-1:0]    waitCnt;
        logic                hostReady;
        logic                writePrev;
        logic                adsPrev;
        logic [ADDR_W-1:0]   latchAddr;
        logic                latchAen;
        logic [BE_W-1:0]     latchBeN;
        logic                accessStrobe;
        logic                accessWrite;
        logic                accessQueue;
        logic [ADDR_W-1:0]   accessAddr;
        logic [BE_W-1:0]     accessBeN;
        logic [DATA_W-1:0]   accessWriteData;
        logic [DATA_W-1:0]   hostReadData;
        logic                hostReadOe;
    } ahbwc_regs_t;

endpackage : ahbwc_pkg

// ===== verilog/ahbwc_sync.sv
// Purpose: Two-stage synchroniser for a bundle of host pins
// Assumes: Each bit is a level; bundle skew is settled by the host's setup
// Notes:   Stage one is read only by stage two
`timescale 1ns/100ps
module ahbwc_sync #(
    parameter int               WIDTH    = 1,
    parameter logic [WIDTH-1:0] RST_VAL  = '0
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;

    // Two flops in series, reset to the idle level of each pin
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= RST_VAL;
            syncOut    <= RST_VAL;
        end else begin
            stage1_reg <= pinIn;
            syncOut    <= stage1_reg;
        end
    end

endmodule : ahbwc_sync

// ===== verilog/ahbwc_ctrl.sv
// Purpose: Device side of the asynchronous host bus with host-ready wait control
// Assumes: Host pins are asynchronous; core answers read data within the wait time
// Notes:   Pin to host-ready latency is the synchroniser depth plus one cycle
`timescale 1ns/100ps
module ahbwc_ctrl
(
    input  wire logic                          clk,
    input  wire logic                          nrst,
    // Host pins
    input  wire logic                          addressLatchStrobeN,
    input  wire logic                          readStrobeN,
    input  wire logic                          writeStrobeN,
    input  wire logic                          dataWindowSelectN,
    input  wire logic                          addressEnable,
    input  wire logic [ahbwc_pkg::BE_W-1:0]    byteLaneEnableN,
    input  wire logic [ahbwc_pkg::ADDR_W-1:0]  hostAddressBus,
    input  wire logic [ahbwc_pkg::DATA_W-1:0]  hostWriteData,
    output logic      [ahbwc_pkg::DATA_W-1:0]  hostReadData,
    output logic                               hostReadOe,
    output logic                               hostReady,
    // Strap style mode inputs
    input  wire logic                          turboMode,
    input  wire logic                          addrLatchMode,
    input  wire logic                          dataWindowMode,
    // Core side
    output logic                               accessStrobe,
    output logic                               accessWrite,
    output logic                               accessQueue,
    output logic      [ahbwc_pkg::ADDR_W-1:0]  accessAddr,
    output logic      [ahbwc_pkg::BE_W-1:0]    accessBeN,
    output logic      [ahbwc_pkg::DATA_W-1:0]  accessWriteData,
    input  wire logic [ahbwc_pkg::DATA_W-1:0]  coreReadData
);
    import ahbwc_pkg::*;

    logic [SYNC_W-1:0]  pinSync;
    ahbwc_regs_t        r_reg;
    ahbwc_regs_t        r_next;

    logic               adsS;
    logic               rdS;
    logic               wrS;
    logic               dcsS;
    logic               aenS;
    logic               turboS;
    logic               latchS;
    logic               winS;
    logic [BE_W-1:0]    beS;
    logic [ADDR_W-1:0]  addrS;
    logic [DATA_W-1:0]  wdataS;
    logic [ADDR_W-1:0]  curAddr;
    logic               curAen;
    logic [BE_W-1:0]    curBeN;
    logic               selected;
    logic               isQueue;
    logic               isBank;
    logic               writeEnd;
    logic [CNT_W-1:0]   readWait;
    logic [CNT_W-1:0]   writeWait;

    // All host pins pass two flops before any logic reads them
    ahbwc_sync #(
        .WIDTH   (SYNC_W),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clk     (clk),
        .nrst    (nrst),
        .pinIn   ({hostWriteData, hostAddressBus, byteLaneEnableN, dataWindowMode,
                   addrLatchMode, turboMode, addressEnable, dataWindowSelectN,
                   writeStrobeN, readStrobeN, addressLatchStrobeN}),
        .syncOut (pinSync)
    );

    // Unpack the synchronised word
    assign adsS   = pinSync[SYNC_ADS];
    assign rdS    = pinSync[SYNC_RD];
    assign wrS    = pinSync[SYNC_WR];
    assign dcsS   = pinSync[SYNC_DCS];
    assign aenS   = pinSync[SYNC_AEN];
    assign turboS = pinSync[SYNC_TURBO];
    assign latchS = pinSync[SYNC_LATCH];
    assign winS   = pinSync[SYNC_WIN];
    assign beS    = pinSync[SYNC_BE +: BE_W];
    assign addrS  = pinSync[SYNC_ADDR +: ADDR_W];
    assign wdataS = pinSync[SYNC_DATA +: DATA_W];

    // Address source: latched copy or live pins held by the host
    always_comb begin
        if (latchS) begin
            curAddr = r_reg.latchAddr;
            curAen  = r_reg.latchAen;
            curBeN  = r_reg.latchBeN;
        end else begin
            curAddr = addrS;
            curAen  = aenS;
            curBeN  = beS;
        end
    end

    // Target decode; in data window mode window select alone picks the queue data register
    always_comb begin
        selected = winS ? !dcsS : curAen;
        isQueue  = winS ? !dcsS : (curAen && (curAddr == QUEUE_DATA_ADDR));
        isBank   = !winS && curAen && (curAddr == BANK_SELECT_ADDR);
    end

    // Wait lengths per target and mode; bank select and others take none
    always_comb begin
        readWait  = CNT_ZERO;
        writeWait = CNT_ZERO;
        if (isQueue && !isBank) begin
            readWait  = turboS ? READ_TURBO_CYCLES : READ_NORMAL_CYCLES;
            writeWait = WRITE_CYCLES;
        end
    end

    // Write is absorbed at the rising edge of the write strobe
    assign writeEnd = wrS && !r_reg.writePrev;

    // Next-state logic for the whole controller
    always_comb begin
        r_next              = r_reg;
        r_next.writePrev    = wrS;
        r_next.adsPrev      = adsS;
        r_next.accessStrobe = 1'b0;
        // Catch address group on the rising edge of the address strobe
        if (adsS && !r_reg.adsPrev) begin
            r_next.latchAddr = addrS;
            r_next.latchAen  = aenS;
            r_next.latchBeN  = beS;
        end
        unique case (r_reg.state)
            AHBWC_IDLE: begin
                r_next.hostReady  = 1'b1;
                r_next.hostReadOe = 1'b0;
                if (writeEnd && selected) begin
                    r_next.accessStrobe    = 1'b1;
                    r_next.accessWrite     = 1'b1;
                    r_next.accessQueue     = isQueue;
                    r_next.accessAddr      = curAddr;
                    r_next.accessBeN       = curBeN;
                    r_next.accessWriteData = wdataS;
                    if (writeWait != CNT_ZERO) begin
                        r_next.hostReady = 1'b0;
                        r_next.waitCnt   = writeWait;
                        r_next.state     = AHBWC_WRITE_WAIT;
                    end
                end else if (!rdS && selected) begin
                    r_next.accessStrobe = 1'b1;
                    r_next.accessWrite  = 1'b0;
                    r_next.accessQueue  = isQueue;
                    r_next.accessAddr   = curAddr;
                    r_next.accessBeN    = curBeN;
                    r_next.hostReadOe   = 1'b1;
                    if (readWait != CNT_ZERO) begin
                        r_next.hostReady = 1'b0;
                        r_next.waitCnt   = readWait;
                        r_next.state     = AHBWC_READ_WAIT;
                    end else begin
                        r_next.hostReadData = coreReadData;
                        r_next.state        = AHBWC_READ_HOLD;
                    end
                end
            end
            AHBWC_READ_WAIT: begin
                r_next.waitCnt = r_reg.waitCnt - CNT_ONE;
                if (r_reg.waitCnt == CNT_ONE) begin
                    // Data and ready are registered in the same cycle; host holds strobe till then
                    r_next.hostReadData = coreReadData;
                    r_next.hostReady    = 1'b1;
                    r_next.state        = AHBWC_READ_HOLD;
                end
            end
            AHBWC_READ_HOLD: begin
                if (rdS) begin
                    r_next.hostReadOe = 1'b0;
                    r_next.state      = AHBWC_IDLE;
                end
            end
            AHBWC_WRITE_WAIT: begin
                r_next.waitCnt = r_reg.waitCnt - CNT_ONE;
                if (r_reg.waitCnt == CNT_ONE) begin
                    // A read begun during the wait is held by its strobe level
                    r_next.hostReady = 1'b1;
                    r_next.state     = AHBWC_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '{state: AHBWC_IDLE, waitCnt: CNT_ZERO, hostReady: 1'b1,
                       writePrev: 1'b1, adsPrev: 1'b1, latchAddr: ADDR_RST,
                       latchAen: 1'b0, latchBeN: BE_RST, accessStrobe: 1'b0,
                       accessWrite: 1'b0, accessQueue: 1'b0, accessAddr: ADDR_RST,
                       accessBeN: BE_RST, accessWriteData: DATA_RST,
                       hostReadData: DATA_RST, hostReadOe: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state register
    assign hostReady       = r_reg.hostReady;
    assign hostReadData    = r_reg.hostReadData;
    assign hostReadOe      = r_reg.hostReadOe;
    assign accessStrobe    = r_reg.accessStrobe;
    assign accessWrite     = r_reg.accessWrite;
    assign accessQueue     = r_reg.accessQueue;
    assign accessAddr      = r_reg.accessAddr;
    assign accessBeN       = r_reg.accessBeN;
    assign accessWriteData = r_reg.accessWriteData;

endmodule : ahbwc_ctrl

// ===== sim/ahbwc_ctrl_properties.sv
// Purpose: Port assertions for the host bus wait controller
// Assumes: Mode pins stay still around accesses
// Notes:   Bound into every ahbwc_ctrl
`timescale 1ns/100ps
module ahbwc_ctrl_properties
(
    input wire logic                         clk,
    input wire logic                         nrst,
    input wire logic                         hostReady,
    input wire logic                         hostReadOe,
    input wire logic [ahbwc_pkg::DATA_W-1:0] hostReadData,
    input wire logic                         turboMode,
    input wire logic                         accessStrobe,
    input wire logic                         accessWrite,
    input wire logic                         accessQueue,
    input wire logic [ahbwc_pkg::DATA_W-1:0] coreReadData
);
    import ahbwc_pkg::*;
    localparam int MAX_LOW = 10;
    logic [3:0] sinceStrobe_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Cycles since the last issued access, saturating
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) sinceStrobe_reg <= 4'hF;
        else if (accessStrobe) sinceStrobe_reg <= 4'h0;
        else if (sinceStrobe_reg != 4'hF) sinceStrobe_reg <= sinceStrobe_reg + 4'h1;
    end
    ready_cause_a: assert property ($fell(hostReady) |-> accessStrobe)
        else $error("ready fell with no access");
    turbo_wait_a: assert property ($fell(hostReady) && !accessWrite && turboMode
        |-> ##1 (!hostReady)[*4] ##1 hostReady) else $error("turbo read wait wrong");
    normal_wait_a: assert property ($fell(hostReady) && !accessWrite && !turboMode
        |-> ##1 (!hostReady)[*8] ##1 !hostReady ##1 hostReady) else $error("read wait wrong");
    write_wait_a: assert property (accessStrobe && accessWrite && accessQueue
        |-> !hostReady ##1 (!hostReady)[*4] ##1 hostReady) else $error("write wait wrong");
    bank_nowait_a: assert property (accessStrobe && !accessQueue |-> hostReady[*3])
        else $error("bank access waited");
    queue_wait_a: assert property (accessStrobe && accessQueue |-> !hostReady)
        else $error("queue access without wait");
    strobe_pulse_a: assert property (accessStrobe |=> !accessStrobe)
        else $error("access strobe too long");
    read_drive_a: assert property (accessStrobe && !accessWrite |-> hostReadOe)
        else $error("read data not driven");
    read_data_a: assert property ($rose(hostReady) && hostReadOe
        |-> hostReadData == $past(coreReadData)) else $error("read data not taken");
    idle_ready_a: assert property (!hostReady && !accessStrobe
        |-> sinceStrobe_reg < MAX_LOW) else $error("ready low while idle");
    cover property (accessStrobe && accessQueue && !accessWrite && turboMode);
    cover property (accessStrobe && accessQueue && !accessWrite && !turboMode);
    cover property (accessStrobe && accessWrite && !accessQueue);
endmodule : ahbwc_ctrl_properties

bind ahbwc_ctrl ahbwc_ctrl_properties ahbwc_ctrl_properties_inst (.clk(clk), .nrst(nrst),
    .hostReady(hostReady), .hostReadOe(hostReadOe), .hostReadData(hostReadData),
    .turboMode(turboMode), .accessStrobe(accessStrobe), .accessWrite(accessWrite),
    .accessQueue(accessQueue), .coreReadData(coreReadData));

// ===== sim/ahbwc_host_model.sv
// Purpose: Host processor on the asynchronous parallel bus
// Assumes: Accesses are started from the bench at falling clock edges
// Notes:   Released address, data and byte enable lines show the inverse of the access value; strobes and selects go idle
`timescale 1ns/100ps
module ahbwc_host_model
(
    input  wire logic                         clk,
    input  wire logic                         hostReady,
    input  wire logic [ahbwc_pkg::DATA_W-1:0] hostReadData,
    input  wire logic                         addrLatchMode,
    output logic                              addressLatchStrobeN,
    output logic                              readStrobeN,
    output logic                              writeStrobeN,
    output logic                              dataWindowSelectN,
    output logic                              addressEnable,
    output logic      [ahbwc_pkg::BE_W-1:0]   byteLaneEnableN,
    output logic      [ahbwc_pkg::ADDR_W-1:0] hostAddressBus,
    output logic      [ahbwc_pkg::DATA_W-1:0] hostWriteData
);
    import ahbwc_pkg::*;
    // Idle bus at time zero
    initial begin
        addressLatchStrobeN = 1'b1;
        readStrobeN         = 1'b1;
        writeStrobeN        = 1'b1;
        dataWindowSelectN   = 1'b1;
        addressEnable       = 1'b0;
        byteLaneEnableN     = 4'hF;
        hostAddressBus      = '0;
        hostWriteData       = '0;
    end
    // One access; starts without looking at ready left by the last one
    task automatic access(input logic wr, input logic win, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd);
        int n;
        n = 0;
        @(negedge clk);
        hostAddressBus    = a;
        addressEnable     = !win;
        byteLaneEnableN   = d[BE_W-1:0];
        hostWriteData     = d;
        dataWindowSelectN = !win;
        if (addrLatchMode) begin
            addressLatchStrobeN = 1'b0;
            repeat (3) @(negedge clk);
            addressLatchStrobeN = 1'b1;
            repeat (3) @(negedge clk);
            hostAddressBus  = ~a;
            addressEnable   = 1'b0;
            byteLaneEnableN = ~d[BE_W-1:0];
        end
        @(negedge clk);
        readStrobeN  = wr;
        writeStrobeN = !wr;
        repeat (4) @(negedge clk);
        while (hostReady !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        rd           = hostReadData;
        readStrobeN  = 1'b1;
        writeStrobeN = 1'b1;
        repeat (3) @(negedge clk);
        hostAddressBus    = ~a;
        hostWriteData     = ~d;
        byteLaneEnableN   = ~d[BE_W-1:0];
        addressEnable     = 1'b0;
        dataWindowSelectN = 1'b1;
    endtask : access
endmodule : ahbwc_host_model

// ===== sim/ahbwc_ctrl_tb.sv
// Purpose: Self-checking bench for the host bus wait controller
// Assumes: Host model drives the pins at falling edges
// Notes:   Wait lengths are counted as ready-low falling edges
`timescale 1ns/100ps
module ahbwc_ctrl_tb;
    import ahbwc_pkg::*;
    logic clk, nrst, address_latch_strobe_n, read_strobe_n, write_strobe_n, dcsN, address_enable, turbo, latchMode, winMode;
    logic rdOe, ready, aStrobe, aWrite, aQueue;
    logic [BE_W-1:0] beN, aBeN;
    logic [ADDR_W-1:0] addr, aAddr;
    logic [DATA_W-1:0] wdata, rdata, coreData, aWdata;
    int errorCnt, cmpCount, lowTotal, strobeTotal;

    ahbwc_ctrl ahbwc_ctrl_inst (.clk(clk), .nrst(nrst), .addressLatchStrobeN(address_latch_strobe_n),
        .readStrobeN(read_strobe_n), .writeStrobeN(write_strobe_n), .dataWindowSelectN(dcsN),
        .addressEnable(address_enable), .byteLaneEnableN(beN), .hostAddressBus(addr),
        .hostWriteData(wdata), .hostReadData(rdata), .hostReadOe(rdOe), .hostReady(ready),
        .turboMode(turbo), .addrLatchMode(latchMode), .dataWindowMode(winMode),
        .accessStrobe(aStrobe), .accessWrite(aWrite), .accessQueue(aQueue),
        .accessAddr(aAddr), .accessBeN(aBeN), .accessWriteData(aWdata),
        .coreReadData(coreData));
    ahbwc_host_model ahbwc_host_model_inst (.clk(clk), .hostReady(ready),
        .hostReadData(rdata), .addrLatchMode(latchMode), .addressLatchStrobeN(address_latch_strobe_n),
        .readStrobeN(read_strobe_n), .writeStrobeN(write_strobe_n), .dataWindowSelectN(dcsN),
        .addressEnable(address_enable), .byteLaneEnableN(beN), .hostAddressBus(addr),
        .hostWriteData(wdata));

    // Clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Running counts of ready-low edges and issued accesses
    always @(negedge clk) begin
        lowTotal    <= lowTotal + int'(ready === 1'b0);
        strobeTotal <= strobeTotal + int'(aStrobe === 1'b1);
    end
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    // Mode pins pass a synchroniser, so let them settle
    task automatic set_mode(input logic t, input logic l, input logic w);
        @(negedge clk);
        turbo     = t;
        latchMode = l;
        winMode   = w;
        repeat (4) @(negedge clk);
    endtask : set_mode
    // One access plus settling; returns wait edges and access count
    task automatic xfer(input logic wr, input logic win, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] lows,
                        output logic [DATA_W-1:0] strobes, output logic [DATA_W-1:0] rd);
        int l0, s0;
        l0 = lowTotal;
        s0 = strobeTotal;
        ahbwc_host_model_inst.access(wr, win, a, d, rd);
        repeat (16) @(negedge clk);
        lows    = DATA_W'(lowTotal - l0);
        strobes = DATA_W'(strobeTotal - s0);
    endtask : xfer
    // Bank select read has no wait; turbo and normal queue reads do
    task automatic t_reads();
        logic [DATA_W-1:0] l, s, rd;
        coreData = 32'h5A5A_0007;
        xfer(1'b0, 1'b0, BANK_SELECT_ADDR, 32'h0, l, s, rd);
        chk(l, 32'h0);
        chk(rd, 32'h5A5A_0007);
        coreData = 32'hC0DE_1234;
        xfer(1'b0, 1'b0, QUEUE_DATA_ADDR, 32'h0, l, s, rd);
        chk(l, 32'h5);
        chk(rd, 32'hC0DE_1234);
        set_mode(1'b0, 1'b0, 1'b0);
        coreData = 32'h0BAD_F00D;
        xfer(1'b0, 1'b0, QUEUE_DATA_ADDR, 32'h0, l, s, rd);
        chk(l, 32'hA);
        chk(rd, 32'h0BAD_F00D);
        set_mode(1'b1, 1'b0, 1'b0);
    endtask : t_reads
    // Writes wait only for the queue data register; data taken at strobe end
    task automatic t_writes();
        logic [DATA_W-1:0] l, s, rd;
        xfer(1'b1, 1'b0, BANK_SELECT_ADDR, 32'h1234_5676, l, s, rd);
        chk(l, 32'h0);
        chk(aWdata, 32'h1234_5676);
        xfer(1'b1, 1'b0, QUEUE_DATA_ADDR, 32'hA5C3_0F1B, l, s, rd);
        chk(l, 32'h5);
        chk(aWdata, 32'hA5C3_0F1B);
        chk({aWrite, aQueue, aBeN}, {2'b11, 4'hB});
        // Second write starts while ready is still low from the first one
        ahbwc_host_model_inst.access(1'b1, 1'b0, QUEUE_DATA_ADDR, 32'h1111_2222, rd);
        xfer(1'b1, 1'b0, QUEUE_DATA_ADDR, 32'h3333_4444, l, s, rd);
        chk(l, 32'hA);
        chk(s, 32'h2);
        chk(aWdata, 32'h3333_4444);
    endtask : t_writes
    // Latched address survives a scrambled bus during the strobe
    task automatic t_latch();
        logic [DATA_W-1:0] l, s, rd;
        set_mode(1'b1, 1'b1, 1'b0);
        xfer(1'b0, 1'b0, QUEUE_DATA_ADDR, 32'h9, l, s, rd);
        chk(l, 32'h5);
        chk({aAddr, aBeN}, {QUEUE_DATA_ADDR, 4'h9});
        set_mode(1'b1, 1'b0, 1'b0);
    endtask : t_latch
    // Window select picks the queue register; unselected access is ignored
    task automatic t_window();
        logic [DATA_W-1:0] l, s, rd;
        set_mode(1'b1, 1'b0, 1'b1);
        xfer(1'b0, 1'b1, 15'h0100, 32'h0, l, s, rd);
        chk(l, 32'h5);
        chk({31'h0, aQueue}, 32'h1);
        set_mode(1'b1, 1'b0, 1'b0);
        xfer(1'b0, 1'b1, QUEUE_DATA_ADDR, 32'h0, l, s, rd);
        chk(l, 32'h0);
        chk(s, 32'h0);
    endtask : t_window
    // Watchdog
    initial begin
        #50000;
        errorCnt++;
        conclude();
    end
    initial begin
        nrst        = 1'b0;
        turbo       = 1'b1;
        latchMode   = 1'b0;
        winMode     = 1'b0;
        coreData    = '0;
        errorCnt    = 0;
        cmpCount    = 0;
        lowTotal    = 0;
        strobeTotal = 0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        chk({ready, rdOe, aStrobe, aBeN}, {3'b100, 4'hF});
        repeat (4) @(negedge clk);
        t_reads();
        t_writes();
        t_latch();
        t_window();
        conclude();
    end
endmodule : ahbwc_ctrl_tb
